// File: sim/test_two_wire_register_port.sv
// Bench: host and sensor face each other; queues hold expected results.
// Assumes the shortened counts set on the instances below.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module test_two_wire_register_port;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic wr = 1'b0;
  logic resync = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic busy, done, wr_stb, sclk_q, rd_op;
  logic dev_busy, dev_drive;
  logic [6:0] wr_addr, a1;
  logic [7:0] rdata, wr_data, d1;
  logic [15:0] fr;
  logic [15:0] q_fr[$];
  logic [15:0] q_wr[$];
  logic [15:0] q_rd[$];
  int num_errors = 0;
  int n_tests = 0;
  int cnt = 0;

  two_wire_if lnk();
  two_wire_host #(.FETCH_CYC(300), .WR_GAP_CYC(40), .PD_HOLD_CYC(40)) two_wire_host_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .link(lnk.host), .start_i(start),
    .write_i(wr), .addr_i(addr), .wdata_i(wdata), .resync_i(resync), .busy_o(busy),
    .done_o(done), .rdata_o(rdata));
  two_wire_sensor #(.PD_HOLD_CYC(40), .WDOG_CYC(2000)) two_wire_sensor_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .link(lnk.device), .wr_stb_o(wr_stb),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .busy_o(dev_busy), .drive_o(dev_drive));
  two_wire_props two_wire_props_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk(lnk.sclk), .power_down_in(lnk.power_down_in),
    .host_sdio_o(lnk.host_sdio_o), .host_sdio_oe(lnk.host_sdio_oe),
    .dev_sdio_o(lnk.dev_sdio_o), .dev_sdio_oe(lnk.dev_sdio_oe), .sdio(lnk.sdio));

  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // An empty queue means the result was never due
  task automatic take(ref logic [15:0] q[$], input logic [15:0] seen);
    if (q.size() == 0) check(seen, ~seen);
    else check(seen, q.pop_front());
  endtask

  task end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Bounded wait, sampled mid-cycle so edge updates have landed
  task wait_done;
    int i;
    i = 0;
    while (done !== 1'b1 && i < 3000) begin
      @(negedge clk_i);
      i++;
    end
    if (i == 3000) check(16'h0001, 16'h0000);
    @(posedge clk_i);
  endtask

  // One frame; expectations noted before the request goes out
  task op(input logic w, input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
    q_fr.push_back({w, a, w ? d : e});
    if (w && a != `ID_ADDR && a < 7'd16) q_wr.push_back({1'b0, a, d});
    if (!w) q_rd.push_back({8'h00, e});
    rd_op = !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    // Freeze both ends mid-address; the frame only lands if both halt
    repeat (40) @(posedge clk_i);
    ce <= 1'b0;
    repeat (20) @(posedge clk_i);
    ce <= 1'b1;
    wait_done();
  endtask

  // ----------------------------------------------------------------
  // Clock, watchers and watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Wire frames are rebuilt from the line at each clock rise
  always @(negedge clk_i) begin
    if (!arst_n_i) begin
      cnt = 0;
      sclk_q = 1'b1;
    end else begin
      if (lnk.sclk === 1'b1 && sclk_q === 1'b0) begin
        fr = {fr[14:0], lnk.sdio};
        cnt++;
        if (cnt == 16) take(q_fr, fr);
        if (cnt == 16) cnt = 0;
      end
      sclk_q = lnk.sclk;
      if (wr_stb === 1'b1) take(q_wr, {1'b0, wr_addr, wr_data});
      if (done === 1'b1 && rd_op) take(q_rd, {8'h00, rdata});
      if (done === 1'b1) check(16'({busy, dev_busy, dev_drive}), 16'({2'b00, rd_op}));
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rd_op = 1'b0;
    void'($urandom(32'hbf323fb2));
    a1 = 7'($urandom_range(15, 1));
    d1 = 8'($urandom);
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    op(1'b1, a1, d1, 8'h00);
    op(1'b0, a1, 8'h00, d1);
    $display("test write and read back done");
    op(1'b1, `ID_ADDR, d1, 8'h00);
    op(1'b0, `ID_ADDR, 8'h00, `ID_VALUE);
    op(1'b1, 7'h40, d1, 8'h00);
    op(1'b0, 7'h40, 8'h00, 8'h00);
    $display("test invalid addresses done");
    rd_op = 1'b0;
    resync <= 1'b1;
    @(posedge clk_i);
    resync <= 1'b0;
    wait_done();
    op(1'b0, a1, 8'h00, d1);
    $display("test resync done");
    check(16'(q_fr.size() + q_wr.size() + q_rd.size()), 16'h0000);
    end_sim();
  end
endmodule

`default_nettype wire

// File: sim/two_wire_props.sv
// Checker for the two-wire link: watches the shared wires only.
// Assumes every link signal is sampled by the host's clk_i.
`timescale 1ns/1ps
`default_nettype none

module two_wire_props #(
  parameter int PD_HOLD_CYC = 40,
  parameter int FETCH_CYC = 300
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Link wires
  input wire logic sclk,
  input wire logic power_down_in,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic sdio
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic sclk_ff;
  logic [3:0] rise_cnt_ff;
  logic [15:0] pd_cnt_ff;
  logic [15:0] fetch_cnt_ff;
  wire sclk_rise = sclk & ~sclk_ff;

  // The power-down and fetch counters saturate, so a long idle never wraps them
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_ff <= 1'b1;
      rise_cnt_ff <= 4'h0;
      pd_cnt_ff <= 16'h0000;
      fetch_cnt_ff <= 16'h0000;
    end else begin
      sclk_ff <= sclk;
      rise_cnt_ff <= !dev_sdio_oe ? 4'h0 : rise_cnt_ff + 4'(sclk_rise);
      pd_cnt_ff <= !power_down_in ? 16'h0000 : pd_cnt_ff + 16'(pd_cnt_ff != 16'hffff);
      fetch_cnt_ff <= host_sdio_oe ? 16'h0000 : fetch_cnt_ff + 16'(fetch_cnt_ff != 16'hffff);
    end
  end

  // ----------------------------------------------------------------
  // Turnaround and handoff
  // ----------------------------------------------------------------
  sequence last_rise;
    $rose(rise_cnt_ff == 4'h8);
  endsequence
  sequence last_fall;
    $fell(sclk) && rise_cnt_ff == 4'h8;
  endsequence

  a_no_bus_fight: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data line");
  a_drive_after_rise: assert property ($rose(dev_sdio_oe) |-> sclk && fetch_cnt_ff > 16'd8)
    else $error("sensor drove before the turnaround");
  a_host_fall_change: assert property (host_sdio_oe && $changed(host_sdio_o) |-> !sclk)
    else $error("host data moved while clock high");
  a_dev_fall_change: assert property (dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_o)
    |-> !sclk)
    else $error("sensor data moved while clock high");
  a_fetch_hold: assert property ($fell(sclk) && !host_sdio_oe |-> fetch_cnt_ff >= FETCH_CYC - 1)
    else $error("clock resumed before fetch time");
  a_last_bit_held: assert property (last_rise |-> dev_sdio_oe [*8])
    else $error("last data bit dropped early");
  a_release_fast: assert property (last_fall |-> ##[1:24] !dev_sdio_oe)
    else $error("sensor kept the line too long");
  a_pd_release: assert property ($fell(power_down_in) && pd_cnt_ff >= PD_HOLD_CYC
    |-> ##[0:8] (!dev_sdio_oe [*4]))
    else $error("line not released by power-down");
  a_quiet_in_pd: assert property (power_down_in |-> $stable(sclk))
    else $error("clock moved during power-down");
endmodule

`default_nettype wire

// File: src/pin_sync.sv
// Two-stage synchroniser for a pin, with edge pulses from a third stage.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Pin and results
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_ff;
  logic level_ff;
  logic prev_ff;

  // Only the second stage reads the first
  // Reset to the idle-high level: no false edge after reset on clock or data;
  // a low-idle pin just reads high for two cycles, which keeps a port idle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= 1'b1;
      level_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else if (ce_i) begin
      meta_ff <= pin_i;
      level_ff <= meta_ff;
      prev_ff <= level_ff;
    end
  end

  // Edges from settled stages only
  assign level_o = level_ff;
  assign rise_o = level_ff & ~prev_ff;
  assign fall_o = ~level_ff & prev_ff;
endmodule

`default_nettype wire

// File: src/two_wire_host.sv
// Host end of the two-wire register port: makes the clock, runs frames.
// Assumes a sensor end that answers reads after the preparation hold.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_host
  import two_wire_pkg::*;
#(
  parameter int FETCH_CYC = `FETCH_CYC,
  parameter int WR_GAP_CYC = `WR_GAP_CYC,
  parameter int PD_HOLD_CYC = `PD_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Link
  two_wire_if.host link,
  // Requests
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic resync_i,
  // Answers
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [15:0] FETCH_LAST = 16'(FETCH_CYC - 1);
  localparam logic [15:0] WGAP_LAST = 16'(WR_GAP_CYC - 1);
  localparam logic [15:0] RGAP_LAST = 16'(`RD_GAP_CYC - 1);
  localparam logic [15:0] PD_LAST = 16'(PD_HOLD_CYC - 1);
  localparam logic [15:0] HALF_LAST = 16'(`HALF_CYC - 1);
  localparam logic [15:0] MID = 16'(`HALF_MID);

  host_state_type state_ff;
  logic [15:0] cnt_ff;
  logic [15:0] sh_ff;
  logic [3:0] bit_ff;
  logic wr_ff;
  logic sclk_ff;
  logic sdo_ff;
  logic soe_ff;
  logic pd_ff;
  logic busy_ff;
  logic done_ff;
  logic [7:0] rdata_ff;
  logic sdio_lvl;

  // Read data comes from the far end, so it is synchronised
  pin_sync sync_sdio (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .pin_i(link.sdio),
    .level_o(sdio_lvl),
    .rise_o(),
    .fall_o()
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire host_drives = wr_ff || (bit_ff <= `LAST_ADDR_BIT);
  wire reading_data = !wr_ff && (bit_ff > `LAST_ADDR_BIT);
  wire [15:0] gap_last = wr_ff ? WGAP_LAST : RGAP_LAST;
  wire [15:0] cnt_inc = cnt_ff + 16'h0001;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // host owns clock and start
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= HST_IDLE;
      cnt_ff <= 16'h0000;
      sh_ff <= 16'h0000;
      bit_ff <= 4'h0;
      wr_ff <= 1'b1;
      sclk_ff <= 1'b1;
      sdo_ff <= 1'b1;
      soe_ff <= 1'b1;
      pd_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      done_ff <= 1'b0;
      cnt_ff <= cnt_inc;
      unique case (state_ff)
        HST_IDLE: begin
          cnt_ff <= 16'h0000;
          if (resync_i) begin
            pd_ff <= 1'b1;
            busy_ff <= 1'b1;
            state_ff <= HST_PD;
          end else if (start_i) begin
            sh_ff <= {write_i, addr_i, wdata_i};
            wr_ff <= write_i;
            bit_ff <= 4'h0;
            busy_ff <= 1'b1;
            sclk_ff <= 1'b0;
            state_ff <= HST_LOW;
          end
        end
        HST_LOW: begin
          // change data while clock low
          // Mid-phase drive gives the sensor time to let go first
          if (cnt_ff == MID && host_drives) begin
            sdo_ff <= sh_ff[15];
            soe_ff <= 1'b1;
          end
          if (cnt_ff == HALF_LAST) begin
            sclk_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            state_ff <= HST_HIGH;
          end
        end
        HST_HIGH: begin
          if (cnt_ff == HALF_LAST) begin
            cnt_ff <= 16'h0000;
            sh_ff <= {sh_ff[14:0], 1'b0};
            // sample sensor data late in high phase
            if (reading_data) begin
              rdata_ff <= {rdata_ff[6:0], sdio_lvl};
            end
            if (bit_ff == `LAST_ADDR_BIT && !wr_ff) begin
              soe_ff <= 1'b0;
              state_ff <= HST_FETCH;
            end else if (bit_ff == `LAST_BIT) begin
              state_ff <= HST_GAP;
            end else begin
              bit_ff <= bit_ff + 4'h1;
              sclk_ff <= 1'b0;
              state_ff <= HST_LOW;
            end
          end
        end
        HST_FETCH: begin
          if (cnt_ff == FETCH_LAST) begin
            cnt_ff <= 16'h0000;
            bit_ff <= bit_ff + 4'h1;
            sclk_ff <= 1'b0;
            state_ff <= HST_LOW;
          end
        end
        HST_GAP: begin
          if (cnt_ff == gap_last) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            state_ff <= HST_IDLE;
          end
        end
        HST_PD: begin
          if (cnt_ff == PD_LAST) begin
            cnt_ff <= 16'h0000;
            pd_ff <= 1'b0;
            wr_ff <= 1'b1;
            state_ff <= HST_GAP;
          end
        end
        default: begin
          state_ff <= HST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // line stays driven after writes; released only after reads
  assign link.sclk = sclk_ff;
  assign link.power_down_in = pd_ff;
  assign link.host_sdio_o = sdo_ff;
  assign link.host_sdio_oe = soe_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign rdata_o = rdata_ff;
endmodule

`default_nettype wire

// File: src/two_wire_if.sv
// Link between host and sensor: clock, power-down and shared data line.
// Assumes the line has a pull-up when neither end drives it.
`timescale 1ns/1ps
`default_nettype none

interface two_wire_if;
  logic sclk;
  logic power_down_in;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;

  // Wire level from the enables, pull-up when released
  assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);

  modport host (
    output sclk,
    output power_down_in,
    output host_sdio_o,
    output host_sdio_oe,
    input sdio
  );

  modport device (
    input sclk,
    input power_down_in,
    input sdio,
    output dev_sdio_o,
    output dev_sdio_oe
  );
endinterface

`default_nettype wire

// File: src/two_wire_map.svh
// Constants for the two-wire register port: timing counts, field layout.
// Assumes a 200 MHz system clock on both ends of the link.
// Notes on behaviour
// - Only host starts transfers and makes clock
// - Write: direction one, address, data byte
// - Host changes on fall, sensor samples rise
// - Read: direction zero, sensor returns data
// - Host releases line after last address bit
// - Sensor drives only after last address rise
// - Host holds clock 100 us before data
// - Sensor holds last bit, releases after fall
// - Next command fall 120 ns after read
// - Host spaces writes 100 us apart
// - Host spaces write then read 100 us
// - No transfers while power-down is high
// - Power-down 100 us releases data line
// - Power-down pulse resets port, keeps registers
// - Transaction timer resets port after 0.9 s
// - Bad address: write ignored, read zero
// - Power-down mid-transfer aborts without writing
// - Host drives idle line, no floating (here the host leaves it released after reads)
// - Host may verify by reading back
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define CLK_MHZ 200
`define CLK_PERIOD_NS 5
`define FETCH_US 100
`define FETCH_CYC (`FETCH_US * `CLK_MHZ)
`define PD_HOLD_US 100
`define PD_HOLD_CYC (`PD_HOLD_US * `CLK_MHZ)
`define WR_GAP_US 100
`define WR_GAP_CYC (`WR_GAP_US * `CLK_MHZ)
`define RD_GAP_NS 120
`define RD_GAP_CYC ((`RD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDOG_MS 900
`define WDOG_CYC (`WDOG_MS * `CLK_MHZ * 1000)
`define PREP_NS 1000
`define PREP_CYC ((`PREP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_CYC 8
`define HALF_MID 4

// ----------------------------------------------------------------
// Frame layout and register space
// ----------------------------------------------------------------
`define DIR_BIT 7
`define DIR_WRITE 1'b1
`define ADDR_W 7
`define LAST_ADDR_BIT 4'h7
`define LAST_BIT 4'hf
`define NUM_REGS 16
`define ID_ADDR 7'h00
`define ID_VALUE 8'h5a
`define REG_RESET 8'h00

`endif

// File: src/two_wire_pkg.sv
// Types shared by both ends of the two-wire register port.
// Assumes nothing beyond a SystemVerilog compiler.
package two_wire_pkg;

  // ----------------------------------------------------------------
  // Sensor end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_ADDR = 3'b001,
    DEV_WDATA = 3'b010,
    DEV_PREP = 3'b011,
    DEV_RDATA = 3'b100
  } dev_state_type;

  // ----------------------------------------------------------------
  // Host end states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_LOW = 3'b001,
    HST_HIGH = 3'b010,
    HST_FETCH = 3'b011,
    HST_GAP = 3'b100,
    HST_PD = 3'b101
  } host_state_type;

endpackage

// File: src/two_wire_sensor.sv
// Sensor end of the two-wire register port: shifts frames in, holds registers.
// Assumes the host keeps its own spacing and turnaround duties.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_sensor
  import two_wire_pkg::*;
#(
  parameter int PD_HOLD_CYC = `PD_HOLD_CYC,
  parameter int WDOG_CYC = `WDOG_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Link
  two_wire_if.device link,
  // Register write notice
  output logic wr_stb_o,
  output logic [6:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  // Status
  output logic busy_o,
  output logic drive_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [7:0] PREP_LAST = 8'(`PREP_CYC - 1);
  localparam logic [27:0] WDOG_LAST = 28'(WDOG_CYC - 1);
  localparam logic [14:0] PD_LAST = 15'(PD_HOLD_CYC - 1);

  dev_state_type state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] adr_ff;
  logic [7:0] dat_ff;
  logic [7:0] prep_ff;
  logic [27:0] wdog_ff;
  logic [14:0] pd_ff;
  logic sdo_ff;
  logic soe_ff;
  logic wr_stb_ff;
  logic [6:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic busy_ff;
  logic [7:0] regs_ff [`NUM_REGS];

  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic sdio_lvl;
  logic pd_lvl;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Clock and data share the same latency, so samples stay aligned
  pin_sync sync_sclk (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .pin_i(link.sclk),
    .level_o(sclk_lvl),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  pin_sync sync_sdio (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .pin_i(link.sdio),
    .level_o(sdio_lvl),
    .rise_o(),
    .fall_o()
  );

  pin_sync sync_pd (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .pin_i(link.power_down_in),
    .level_o(pd_lvl),
    .rise_o(),
    .fall_o()
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Implemented: inside the array, ID slot included; wr_valid also drops the ID slot
  function automatic logic addr_ok(input logic [6:0] a);
    addr_ok = (a < 7'(`NUM_REGS));
  endfunction

  function automatic logic [7:0] read_val(input logic [6:0] a, input logic [7:0] r);
    read_val = (a == `ID_ADDR) ? `ID_VALUE : (addr_ok(a) ? r : 8'h00);
  endfunction

  wire [7:0] adr_next = {adr_ff[6:0], sdio_lvl};
  wire [7:0] dat_next = {dat_ff[6:0], sdio_lvl};
  wire [6:0] cur_addr = adr_ff[6:0];
  wire [7:0] fetched = read_val(cur_addr, regs_ff[cur_addr[3:0]]);
  wire is_write = adr_ff[`DIR_BIT] == `DIR_WRITE;
  wire wdog_hit = (state_ff != DEV_IDLE) && (wdog_ff == WDOG_LAST);
  wire wr_commit = (state_ff == DEV_WDATA) && sclk_rise && (cnt_ff == `LAST_BIT);
  wire wr_valid = addr_ok(cur_addr) && (cur_addr != `ID_ADDR);

  // ----------------------------------------------------------------
  // Power-down hold timer
  // ----------------------------------------------------------------
  // Counts how long power-down has stood high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pd_ff <= 15'h0000;
    end else if (ce_i) begin
      if (!pd_lvl) begin
        pd_ff <= 15'h0000;
      end else if (pd_ff != PD_LAST) begin
        pd_ff <= pd_ff + 15'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transaction timer
  // ----------------------------------------------------------------
  // Started by the first rising edge of a frame
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdog_ff <= 28'h000_0000;
    end else if (ce_i) begin
      if (state_ff == DEV_IDLE) begin
        wdog_ff <= 28'h000_0000;
      end else if (!wdog_hit) begin
        wdog_ff <= wdog_ff + 28'h000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // Sensor never starts a frame; it only follows host clock edges
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= DEV_IDLE;
      cnt_ff <= 4'h0;
      adr_ff <= 8'h00;
      dat_ff <= 8'h00;
      prep_ff <= 8'h00;
      sdo_ff <= 1'b0;
      soe_ff <= 1'b0;
    end else if (ce_i) begin
      if (pd_lvl) begin
        // abort on power-down
        // Port state only; registers untouched, no commit possible
        state_ff <= DEV_IDLE;
        cnt_ff <= 4'h0;
        if (pd_ff == PD_LAST) begin
          soe_ff <= 1'b0;
        end
      end else if (wdog_hit) begin
        state_ff <= DEV_IDLE;
        cnt_ff <= 4'h0;
        soe_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          DEV_IDLE: begin
            if (sclk_fall) begin
              soe_ff <= 1'b0;
            end
            if (sclk_rise) begin
              adr_ff <= adr_next;
              cnt_ff <= 4'h1;
              state_ff <= DEV_ADDR;
            end
          end
          DEV_ADDR: begin
            if (sclk_rise) begin
              adr_ff <= adr_next;
              cnt_ff <= cnt_ff + 4'h1;
              if (cnt_ff == `LAST_ADDR_BIT) begin
                if (adr_ff[6] == `DIR_WRITE) begin
                  state_ff <= DEV_WDATA;
                end else begin
                  prep_ff <= 8'h00;
                  state_ff <= DEV_PREP;
                end
              end
            end
          end
          DEV_WDATA: begin
            if (sclk_rise) begin
              dat_ff <= dat_next;
              cnt_ff <= cnt_ff + 4'h1;
              if (cnt_ff == `LAST_BIT) begin
                state_ff <= DEV_IDLE;
              end
            end
          end
          DEV_PREP: begin
            // drive after last address rise
            // Short settle lets the host release first
            prep_ff <= prep_ff + 8'h01;
            if (prep_ff == PREP_LAST) begin
              // unmapped reads as zero
              // First fall puts bit 7 out again, later falls move one on
              dat_ff <= fetched;
              sdo_ff <= fetched[7];
              soe_ff <= 1'b1;
              state_ff <= DEV_RDATA;
            end
          end
          DEV_RDATA: begin
            if (sclk_fall) begin
              sdo_ff <= dat_ff[7];
              dat_ff <= {dat_ff[6:0], 1'b0};
            end
            if (sclk_rise) begin
              cnt_ff <= cnt_ff + 4'h1;
              if (cnt_ff == `LAST_BIT) begin
                state_ff <= DEV_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register array and write notice
  // ----------------------------------------------------------------
  // unmapped write ignored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_ff[i] <= `REG_RESET;
      end
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= 7'h00;
      wr_data_ff <= 8'h00;
    end else if (ce_i) begin
      wr_stb_ff <= 1'b0;
      if (wr_commit && !pd_lvl && !wdog_hit && is_write && wr_valid) begin
        regs_ff[cur_addr[3:0]] <= dat_next;
        wr_stb_ff <= 1'b1;
        wr_addr_ff <= cur_addr;
        wr_data_ff <= dat_next;
      end
    end
  end

  // Busy flag registered for the user side
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      busy_ff <= (state_ff != DEV_IDLE) && !pd_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.dev_sdio_o = sdo_ff;
  assign link.dev_sdio_oe = soe_ff;
  assign wr_stb_o = wr_stb_ff;
  assign wr_addr_o = wr_addr_ff;
  assign wr_data_o = wr_data_ff;
  assign busy_o = busy_ff;
  assign drive_o = soe_ff;
endmodule

`default_nettype wire
